// >>> core/ifb_pkg.sv
package ifb_pkg;

  // Register byte addresses on the AXI4-Lite port
  localparam logic [31:0] OFF_PIN_EDGE_SELECT = 32'h0000_0000;
  localparam logic [31:0] OFF_PRIMARY_IRQ_CONTROL_0 = 32'h0000_0004;
  localparam logic [31:0] OFF_PRIMARY_IRQ_CONTROL_1 = 32'h0000_0008;
  localparam logic [31:0] OFF_PRIMARY_IRQ_CONTROL_2 = 32'h0000_000C;

  localparam int REG_W = 8;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] MASK_PIN_EDGE_SELECT = 8'h0F;
  localparam logic [7:0] MASK_PRIMARY_IRQ_CONTROL_0 = 8'h7F;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  // pin_edge_select fields
  localparam int POS_EXT_PIN_B_EDGE_SEL = 2;
  localparam int POS_EXT_PIN_A_EDGE_SEL = 0;

  // primary_irq_control_0 fields
  localparam int POS_EXT_PIN_B_REQ = 6;
  localparam int POS_EXT_PIN_A_REQ = 5;
  localparam int POS_LINE_COMP_A_REQ = 4;
  localparam int POS_EXT_PIN_B_EN = 3;
  localparam int POS_EXT_PIN_A_EN = 2;
  localparam int POS_LINE_COMP_A_EN = 1;
  localparam int POS_GLOBAL_IRQ_EN = 0;

  // primary_irq_control_1 fields
  localparam int POS_MULTI_GROUP_B_REQ = 7;
  localparam int POS_MULTI_GROUP_A_REQ = 6;
  localparam int POS_LOW_VOLT_REQ = 5;
  localparam int POS_SERIAL_MODULE_REQ = 4;

  // primary_irq_control_2 fields
  localparam int POS_LINE_COMP_B_REQ = 7;
  localparam int POS_TICK_B_REQ = 6;
  localparam int POS_TICK_A_REQ = 5;
  localparam int POS_MULTI_GROUP_C_REQ = 4;

  // Enables sit four bits below their flags in registers 1 and 2
  localparam int FLAG_TO_EN = 4;
  localparam int NUM_SRC = 12;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } ifb_edge_t;

  typedef struct packed {
    logic line_comp_a;
    logic line_comp_b;
    logic serial_module;
    logic low_volt;
    logic tick_a;
    logic tick_b;
    logic multi_group_a;
    logic multi_group_b;
    logic multi_group_c;
  } ifb_evt_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } ifb_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } ifb_axi_rsp_t;

endpackage

// >>> core/ifb_top.sv
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module ifb_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire ifb_pkg::ifb_evt_t evt,
  input wire ifb_pkg::ifb_axi_req_t axi_req,
  output ifb_pkg::ifb_axi_rsp_t axi_rsp,
  output logic irq_req,
  output logic [ifb_pkg::NUM_SRC-1:0] irq_pending
);

  logic [3:0] edge_sel_q;
  logic [6:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic pin_a_prev_q;
  logic pin_b_prev_q;
  logic pin_a_hit;
  logic pin_b_hit;

  logic aw_held_q;
  logic w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic irq_req_q;
  logic [ifb_pkg::NUM_SRC-1:0] irq_pending_q;

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic commit;
  logic aw_held_d;
  logic w_held_d;
  logic bvalid_d;
  logic rvalid_d;
  logic wr_lane;
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [ifb_pkg::NUM_SRC-1:0] pend_d;

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    case (ifb_pkg::ifb_edge_t'(sel))
      ifb_pkg::EDGE_OFF: edge_hit = 1'b0;
      ifb_pkg::EDGE_RISE: edge_hit = rise;
      ifb_pkg::EDGE_FALL: edge_hit = fall;
      ifb_pkg::EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic addr_is(input logic [31:0] addr, input logic [31:0] off);
    addr_is = (addr[31:2] == off[31:2]);
  endfunction

  // Pins are taken as synchronous; only the previous level is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_a_prev_q <= 1'b0;
      pin_b_prev_q <= 1'b0;
    end else if (clk_en) begin
      pin_a_prev_q <= ext_irq_pin_a;
      pin_b_prev_q <= ext_irq_pin_b;
    end
  end

  assign pin_b_hit = edge_hit(edge_sel_q[ifb_pkg::POS_EXT_PIN_B_EDGE_SEL +: 2], ext_irq_pin_b,
    pin_b_prev_q);
  assign pin_a_hit = edge_hit(edge_sel_q[ifb_pkg::POS_EXT_PIN_A_EDGE_SEL +: 2], ext_irq_pin_a,
    pin_a_prev_q);

  // Write channel handshake
  assign aw_take = axi_req.awvalid & awready_q;
  assign w_take = axi_req.wvalid & wready_q;
  assign commit = aw_held_q & w_held_q & ~bvalid_q;
  assign aw_held_d = (aw_held_q | aw_take) & ~commit;
  assign w_held_d = (w_held_q | w_take) & ~commit;
  assign bvalid_d = commit | (bvalid_q & ~axi_req.bready);
  assign wr_lane = commit & wstrb_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= ifb_pkg::RESP_OKAY;
    end else if (clk_en) begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      if (aw_take) begin
        awaddr_q <= axi_req.awaddr;
      end
      if (w_take) begin
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      awready_q <= ~aw_held_d & ~bvalid_d;
      wready_q <= ~w_held_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (commit) begin
        bresp_q <= (addr_is(awaddr_q, ifb_pkg::OFF_PIN_EDGE_SELECT) ||
                    addr_is(awaddr_q, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_0) ||
                    addr_is(awaddr_q, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_1) ||
                    addr_is(awaddr_q, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_2)) ?
                   ifb_pkg::RESP_OKAY : ifb_pkg::RESP_SLVERR;
      end
    end
  end

  // Hardware set masks; groups arrive already combined from their sub-registers
  always_comb begin
    set0 = ifb_pkg::RST_REG;
    set1 = ifb_pkg::RST_REG;
    set2 = ifb_pkg::RST_REG;
    set0[ifb_pkg::POS_EXT_PIN_B_REQ] = pin_b_hit;
    set0[ifb_pkg::POS_EXT_PIN_A_REQ] = pin_a_hit;
    set0[ifb_pkg::POS_LINE_COMP_A_REQ] = evt.line_comp_a;
    set1[ifb_pkg::POS_MULTI_GROUP_B_REQ] = evt.multi_group_b;
    set1[ifb_pkg::POS_MULTI_GROUP_A_REQ] = evt.multi_group_a;
    set1[ifb_pkg::POS_LOW_VOLT_REQ] = evt.low_volt;
    set1[ifb_pkg::POS_SERIAL_MODULE_REQ] = evt.serial_module;
    set2[ifb_pkg::POS_LINE_COMP_B_REQ] = evt.line_comp_b;
    set2[ifb_pkg::POS_TICK_B_REQ] = evt.tick_b;
    set2[ifb_pkg::POS_TICK_A_REQ] = evt.tick_a;
    set2[ifb_pkg::POS_MULTI_GROUP_C_REQ] = evt.multi_group_c;
  end

  // A hardware set in the same cycle as a software clear wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_sel_q <= 4'h0;
      ctrl0_q <= 7'h00;
      ctrl1_q <= ifb_pkg::RST_REG;
      ctrl2_q <= ifb_pkg::RST_REG;
    end else if (clk_en) begin
      if (wr_lane && addr_is(awaddr_q, ifb_pkg::OFF_PIN_EDGE_SELECT)) begin
        edge_sel_q <= wdata_q[3:0];
      end
      if (wr_lane && addr_is(awaddr_q, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_0)) begin
        ctrl0_q <= wdata_q[6:0] | set0[6:0];
      end else begin
        ctrl0_q <= ctrl0_q | set0[6:0];
      end
      if (wr_lane && addr_is(awaddr_q, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_1)) begin
        ctrl1_q <= wdata_q[7:0] | set1;
      end else begin
        ctrl1_q <= ctrl1_q | set1;
      end
      if (wr_lane && addr_is(awaddr_q, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_2)) begin
        ctrl2_q <= wdata_q[7:0] | set2;
      end else begin
        ctrl2_q <= ctrl2_q | set2;
      end
    end
  end

  // Read channel
  assign ar_take = axi_req.arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~axi_req.rready);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (addr_is(axi_req.araddr, ifb_pkg::OFF_PIN_EDGE_SELECT)) begin
      rd_word[7:0] = {4'h0, edge_sel_q} & ifb_pkg::MASK_PIN_EDGE_SELECT;
    end else if (addr_is(axi_req.araddr, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_0)) begin
      rd_word[7:0] = {1'b0, ctrl0_q} & ifb_pkg::MASK_PRIMARY_IRQ_CONTROL_0;
    end else if (addr_is(axi_req.araddr, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_1)) begin
      rd_word[7:0] = ctrl1_q & ifb_pkg::MASK_FULL;
    end else if (addr_is(axi_req.araddr, ifb_pkg::OFF_PRIMARY_IRQ_CONTROL_2)) begin
      rd_word[7:0] = ctrl2_q & ifb_pkg::MASK_FULL;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= ifb_pkg::RESP_OKAY;
    end else if (clk_en) begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_hit ? ifb_pkg::RESP_OKAY : ifb_pkg::RESP_SLVERR;
      end
    end
  end

  // Pending vector: flag and its own enable, gated by the global enable
  always_comb begin
    pend_d = '0;
    pend_d[0] = ctrl0_q[ifb_pkg::POS_EXT_PIN_B_REQ] & ctrl0_q[ifb_pkg::POS_EXT_PIN_B_EN];
    pend_d[1] = ctrl0_q[ifb_pkg::POS_EXT_PIN_A_REQ] & ctrl0_q[ifb_pkg::POS_EXT_PIN_A_EN];
    pend_d[2] = ctrl0_q[ifb_pkg::POS_LINE_COMP_A_REQ] & ctrl0_q[ifb_pkg::POS_LINE_COMP_A_EN];
    for (int i = 0; i < 4; i++) begin
      pend_d[3 + i] = ctrl1_q[ifb_pkg::FLAG_TO_EN + i] & ctrl1_q[i];
      pend_d[7 + i] = ctrl2_q[ifb_pkg::FLAG_TO_EN + i] & ctrl2_q[i];
    end
    if (!ctrl0_q[ifb_pkg::POS_GLOBAL_IRQ_EN]) begin
      pend_d = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_q <= 1'b0;
      irq_pending_q <= '0;
    end else if (clk_en) begin
      irq_pending_q <= pend_d;
      irq_req_q <= |pend_d;
    end
  end

  assign axi_rsp.awready = awready_q;
  assign axi_rsp.wready = wready_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.arready = arready_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign irq_req = irq_req_q;
  assign irq_pending = irq_pending_q;

endmodule

`default_nettype wire

// >>> verification/ifb_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ifb_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ifb_pkg::ifb_axi_req_t axi_req,
  input wire ifb_pkg::ifb_axi_rsp_t axi_rsp,
  input wire logic irq_req,
  input wire logic [ifb_pkg::NUM_SRC-1:0] irq_pending
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  req_sum_a: assert property (irq_req == (irq_pending != '0)) else $error("irq out of step");
  wr_lat_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |-> ##2 axi_rsp.bvalid) else $error("write answer late");
  rd_lat_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read answer late");
  b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read answer dropped");
  ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("read taken while busy");
  aw_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while busy");
  rd_upper_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  bad_addr_a: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr[31:4] != '0
    |=> axi_rsp.rresp == ifb_pkg::RESP_SLVERR && axi_rsp.rdata == 32'h0000_0000) else $error("unmapped read");
endmodule
bind ifb_top ifb_chk u_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .irq_req(irq_req), .irq_pending(irq_pending));
`default_nettype wire

// >>> verification/ifb_src.sv
`timescale 1ns/100ps
`default_nettype none
module ifb_src (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [3:0] fire_idx,
  output var ifb_pkg::ifb_evt_t evt
);
  // Group inputs arrive already merged from their sub-sources
  initial evt = '0;
  always @(posedge aclk) begin
    evt <= fire ? ifb_pkg::ifb_evt_t'(9'h100 >> fire_idx) : '0;
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic aclk, aresetn, pin_a, pin_b, fire, clk_en;
  logic [3:0] fire_idx;
  ifb_pkg::ifb_evt_t evt;
  ifb_pkg::ifb_axi_req_t axi_req;
  ifb_pkg::ifb_axi_rsp_t axi_rsp;
  logic irq_req;
  logic [11:0] irq_pending;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [33:0] e;
  int n_errors = 0;
  int compares = 0;
  int adr[9] = '{4, 12, 8, 8, 12, 12, 8, 8, 12};
  int fbit[9] = '{4, 7, 4, 5, 5, 6, 6, 7, 4};
  int pbit[9] = '{2, 10, 3, 4, 8, 9, 5, 6, 7};
  ifb_top DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .evt(evt), .axi_req(axi_req), .axi_rsp(axi_rsp), .irq_req(irq_req), .irq_pending(irq_pending));
  ifb_src u_src (.aclk(aclk), .fire(fire), .fire_idx(fire_idx), .evt(evt));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask
  task automatic chk_resp(input logic [1:0] ex, input logic [1:0] got);
    chk({30'h0, ex}, {30'h0, got});
  endtask
  task automatic chk_irq(input logic [12:0] ex);
    // Flag edge, then pending edge, then one more so the sample is settled
    repeat (3) @(posedge aclk);
    chk({19'h0, ex}, {19'h0, irq_req, irq_pending});
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic done_or_quit(input logic ok);
    if (!ok) begin
      n_errors++;
      end_of_test();
    end
  endtask
  task automatic wr(input int a, input logic [7:0] d, input logic [1:0] er = ifb_pkg::RESP_OKAY);
    int n;
    bq.push_back(er);
    @(posedge aclk);
    axi_req.awaddr <= 32'(a);
    axi_req.wdata <= {24'h00_0000, d};
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      n++;
    end while (!axi_rsp.bvalid && n < 100);
    axi_req.bready <= 1'b0;
    done_or_quit(axi_rsp.bvalid);
  endtask
  task automatic rd(input int a, input logic [7:0] d, input logic [1:0] er = ifb_pkg::RESP_OKAY);
    int n;
    rq.push_back({er, 24'h00_0000, d});
    @(posedge aclk);
    axi_req.araddr <= 32'(a);
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      n++;
    end while (!axi_rsp.rvalid && n < 100);
    axi_req.rready <= 1'b0;
    done_or_quit(axi_rsp.rvalid);
  endtask
  // Results are judged at the handshake edge, oldest note first
  always @(posedge aclk) begin
    if (axi_rsp.rvalid && axi_req.rready) begin
      e = rq.pop_front();
      chk(e[31:0], axi_rsp.rdata);
      chk_resp(e[33:32], axi_rsp.rresp);
    end
    if (axi_rsp.bvalid && axi_req.bready) chk_resp(bq.pop_front(), axi_rsp.bresp);
  end
  initial begin
    int i;
    logic [7:0] v, fb, en;
    aresetn = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b0;
    fire = 1'b0;
    clk_en = 1'b1;
    fire_idx = 4'h0;
    axi_req = '0;
    void'($urandom(32'h0000_a823));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 5; i++) rd(4 * i, 8'h00, i < 4 ? ifb_pkg::RESP_OKAY : ifb_pkg::RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom());
      wr(4 * i, v);
      rd(4 * i, v & (i == 0 ? 8'h0F : i == 1 ? 8'h7F : 8'hFF));
      wr(4 * i, 8'h00);
    end
    wr(16, 8'hFF, ifb_pkg::RESP_SLVERR);
    // Both pins share each mode; clearing between edges isolates rise from fall
    for (i = 0; i < 4; i++) begin
      wr(0, 8'(i * 5));
      pin_a <= 1'b1;
      pin_b <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(4, i[0] ? 8'h60 : 8'h00);
      wr(4, 8'h00);
      pin_a <= 1'b0;
      pin_b <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(4, i[1] ? 8'h60 : 8'h00);
    end
    // Falling edges leave both pin flags set
    wr(4, 8'h00);
    wr(0, 8'h00);
    for (i = 0; i < 9; i++) begin
      fb = 8'(1 << fbit[i]);
      en = adr[i] == 4 ? 8'h02 : 8'(1 << (fbit[i] - 4));
      fire_idx <= 4'(i);
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      rd(adr[i], fb);
      wr(adr[i], fb | en);
      chk_irq(13'h0000);
      wr(4, adr[i] == 4 ? fb | en | 8'h01 : 8'h01);
      chk_irq({1'b1, 12'(1 << pbit[i])});
      wr(adr[i], fb);
      chk_irq(13'h0000);
      wr(4, 8'h00);
      wr(adr[i], 8'h00);
    end
    // An event while the clock enable is low must leave no flag
    fire_idx <= 4'h0;
    fire <= 1'b1;
    clk_en <= 1'b0;
    @(posedge aclk);
    fire <= 1'b0;
    repeat (2) @(posedge aclk);
    clk_en <= 1'b1;
    rd(4, 8'h00);
    wr(0, 8'h0F);
    wr(4, 8'h0D);
    pin_b <= 1'b1;
    chk_irq({1'b1, 12'h001});
    end_of_test();
  end
endmodule
`default_nettype wire
